// File: pkg/acx_pkg.sv
// Constants for the accumulator control-register transfer block.
// Assumes a single 125 MHz clock and an Avalon-MM word-aligned register map.
`default_nettype none

package acx_pkg;

    localparam int DATA_W = 4;
    localparam int OP_W = 10;
    localparam int ADDR_W = 6;
    localparam int BUS_W = 32;
    localparam int WAKE_N = 4;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_ACC = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_INTCTL1 = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_WAKE0 = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_INSTR = 6'h1C;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h20;

    // Field positions
    localparam int FLAGS_CARRY_BIT = 0;
    localparam int FLAGS_SKIP_BIT = 1;
    localparam int STATUS_HIT_BIT = 0;
    localparam int STATUS_EXEC_BIT = 1;

    // Values after reset
    localparam logic [DATA_W-1:0] RST_NIBBLE = 4'h0;
    localparam logic [OP_W-1:0] RST_OPCODE = 10'h000;

    // Opcodes of the transfer group
    localparam logic [OP_W-1:0] OP_XFER_INTCTL1 = 10'h253;
    localparam logic [OP_W-1:0] OP_XFER_WAKE0 = 10'h258;
    localparam logic [OP_W-1:0] OP_XFER_WAKE1 = 10'h259;
    localparam logic [OP_W-1:0] OP_XFER_WAKE2 = 10'h25A;
    localparam logic [OP_W-1:0] OP_XFER_WAKE3 = 10'h25B;

    typedef enum {
        SRC_NONE,
        SRC_INTCTL1,
        SRC_WAKE0,
        SRC_WAKE1,
        SRC_WAKE2,
        SRC_WAKE3
    } acx_src_t;

endpackage

`default_nettype wire

// File: rtl/acx_xfer_decode.sv
// Opcode decoder for the control-register-to-accumulator transfers.
// Purely combinational; the caller qualifies it with its own strobe.
`default_nettype none

module acx_xfer_decode
    import acx_pkg::*;
(
    input wire logic [OP_W-1:0] opcode, // Instruction word
    output acx_src_t src,               // Selected source register
    output logic hit,                   // Opcode belongs to this group
    output logic is_wake,               // Source is a wakeup register
    output logic [1:0] wake_idx         // Wakeup register index
);

    always_comb begin
        src = SRC_NONE;
        wake_idx = 2'h0;
        unique case (opcode)
            OP_XFER_INTCTL1: src = SRC_INTCTL1;
            OP_XFER_WAKE0: begin
                src = SRC_WAKE0;
                wake_idx = 2'h0;
            end
            OP_XFER_WAKE1: begin
                src = SRC_WAKE1;
                wake_idx = 2'h1;
            end
            OP_XFER_WAKE2: begin
                src = SRC_WAKE2;
                wake_idx = 2'h2;
            end
            OP_XFER_WAKE3: begin
                src = SRC_WAKE3;
                wake_idx = 2'h3;
            end
            default: src = SRC_NONE;
        endcase
        hit = (src != SRC_NONE);
        is_wake = hit && (src != SRC_INTCTL1);
    end

endmodule

`default_nettype wire

// File: rtl/acx_xfer_core.sv
// Accumulator and control-register transfer core with an Avalon-MM slave.
// Assumes a master that holds each request until waitrequest is seen low.
// Summary of operation
// - Interrupt-control transfer loads accumulator fully.
// - Wakeup-zero transfer copies register into accumulator.
// - Opcode 1001011001 loads from wakeup register one.
// - Opcode 1001011010 loads from wakeup register two.
// - Opcode 1001011011 loads from wakeup register three.
// - Wakeup transfers are I/O reads, registers readable.
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`default_nettype none

module acx_xfer_core
    import acx_pkg::*;
(
    input wire logic MCLK,                      // System clock, 125 MHz
    input wire logic RST,                       // Asynchronous reset, active high
    input wire logic [ADDR_W-1:0] AVS_ADDRESS,  // Byte address
    input wire logic AVS_READ,                  // Read request
    input wire logic AVS_WRITE,                 // Write request
    input wire logic [3:0] AVS_BYTEENABLE,      // Byte lanes
    input wire logic [BUS_W-1:0] AVS_WRITEDATA, // Write data
    output logic [BUS_W-1:0] AVS_READDATA,      // Read data
    output logic AVS_WAITREQUEST,               // Stall request
    output logic [DATA_W-1:0] ACC_OUT,          // Accumulator
    output logic CARRY_OUT,                     // Carry flag
    output logic XFER_DONE                      // Pulse after a transfer
);

    logic ack_q, ack_d;
    logic [BUS_W-1:0] rdata_q, rdata_d;
    logic [DATA_W-1:0] acc_q, acc_d;
    logic carry_q, carry_d;
    logic [DATA_W-1:0] int1_q, int1_d;
    logic [DATA_W-1:0] wake_q [WAKE_N];
    logic [DATA_W-1:0] wake_d [WAKE_N];
    logic [OP_W-1:0] ir_q, ir_d;
    logic hit_q, hit_d;
    logic done_q, done_d;

    logic req;
    logic wr_acc;
    logic rd_acc;
    logic lane0;
    logic exec;
    logic [3:0] reg_idx;
    acx_src_t dec_src;
    logic dec_hit;
    logic dec_wake;
    logic [1:0] dec_widx;

    // A request is accepted one cycle after it appears, giving a
    // registered read path without extra latency on the core side.
    assign req = AVS_READ || AVS_WRITE;
    assign AVS_WAITREQUEST = req && !ack_q;
    assign wr_acc = AVS_WRITE && ack_q;
    assign rd_acc = AVS_READ && !ack_q;
    assign lane0 = AVS_BYTEENABLE[0];
    assign reg_idx = AVS_ADDRESS[ADDR_W-1:2];
    assign exec = wr_acc && (AVS_ADDRESS == OFS_INSTR) && (AVS_BYTEENABLE[1:0] == 2'h3);

    acx_xfer_decode u_dec (
        .opcode(AVS_WRITEDATA[OP_W-1:0]),
        .src(dec_src),
        .hit(dec_hit),
        .is_wake(dec_wake),
        .wake_idx(dec_widx)
    );

    function automatic logic [BUS_W-1:0] rd_mux(
        input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] acc,
        input logic cy,
        input logic [DATA_W-1:0] i1,
        input logic [DATA_W-1:0] w0,
        input logic [DATA_W-1:0] w1,
        input logic [DATA_W-1:0] w2,
        input logic [DATA_W-1:0] w3,
        input logic [OP_W-1:0] ir,
        input logic h,
        input logic d
    );
        logic [BUS_W-1:0] r;
        r = '0;
        unique case (a)
            OFS_ACC: r[DATA_W-1:0] = acc;
            OFS_FLAGS: r[FLAGS_CARRY_BIT] = cy;
            OFS_INTCTL1: r[DATA_W-1:0] = i1;
            OFS_WAKE0: r[DATA_W-1:0] = w0;
            OFS_WAKE0 + 6'h04: r[DATA_W-1:0] = w1;
            OFS_WAKE0 + 6'h08: r[DATA_W-1:0] = w2;
            OFS_WAKE0 + 6'h0C: r[DATA_W-1:0] = w3;
            OFS_INSTR: r[OP_W-1:0] = ir;
            OFS_STATUS: begin
                r[STATUS_HIT_BIT] = h;
                r[STATUS_EXEC_BIT] = d;
            end
            default: r = '0;
        endcase
        return r;
    endfunction

    // Bus handshake and read data
    always_comb begin
        ack_d = req && !ack_q;
        rdata_d = rdata_q;
        if (rd_acc) begin
            rdata_d = rd_mux(AVS_ADDRESS, acc_q, carry_q, int1_q, wake_q[0], wake_q[1],
                             wake_q[2], wake_q[3], ir_q, hit_q, done_q);
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // Architectural state and instruction execution
    always_comb begin
        acc_d = acc_q;
        carry_d = carry_q;
        int1_d = int1_q;
        wake_d = wake_q;
        ir_d = ir_q;
        hit_d = hit_q;
        done_d = 1'b0;
        if (wr_acc && lane0) begin
            if (AVS_ADDRESS == OFS_ACC) begin
                acc_d = AVS_WRITEDATA[DATA_W-1:0];
            end
            if (AVS_ADDRESS == OFS_FLAGS) begin
                carry_d = AVS_WRITEDATA[FLAGS_CARRY_BIT];
            end
            if (AVS_ADDRESS == OFS_INTCTL1) begin
                int1_d = AVS_WRITEDATA[DATA_W-1:0];
            end
            for (int i = 0; i < WAKE_N; i++) begin
                // Aligned offsets only, matching the read decode
                if ((AVS_ADDRESS[1:0] == 2'h0) &&
                    (reg_idx == OFS_WAKE0[ADDR_W-1:2] + 4'(i))) begin
                    wake_d[i] = AVS_WRITEDATA[DATA_W-1:0];
                end
            end
        end
        // Single-cycle execute at the accepting edge; carry never touched
        if (exec) begin
            ir_d = AVS_WRITEDATA[OP_W-1:0];
            hit_d = dec_hit;
            done_d = dec_hit;
            if (dec_src == SRC_INTCTL1) begin
                acc_d = int1_q;
            end else if (dec_wake) begin
                acc_d = wake_q[dec_widx];
            end
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            acc_q <= RST_NIBBLE;
            carry_q <= 1'b0;
            int1_q <= RST_NIBBLE;
            for (int i = 0; i < WAKE_N; i++) begin
                wake_q[i] <= RST_NIBBLE;
            end
            ir_q <= RST_OPCODE;
            hit_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            carry_q <= carry_d;
            int1_q <= int1_d;
            wake_q <= wake_d;
            ir_q <= ir_d;
            hit_q <= hit_d;
            done_q <= done_d;
        end
    end

    assign AVS_READDATA = rdata_q;
    assign ACC_OUT = acc_q;
    assign CARRY_OUT = carry_q;
    assign XFER_DONE = done_q;

    // Checks
    logic [OP_W-1:0] op_w;
    assign op_w = AVS_WRITEDATA[OP_W-1:0];

    property p_int1_xfer;
        @(posedge MCLK) disable iff (RST)
        exec && op_w == OP_XFER_INTCTL1 |=> acc_q == $past(int1_q) && done_q;
    endproperty
    a_int1_xfer: assert property (p_int1_xfer) else $error("acc not loaded from intctl1");

    property p_wake0_xfer;
        @(posedge MCLK) disable iff (RST)
        exec && op_w == OP_XFER_WAKE0 |=> acc_q == $past(wake_q[0]);
    endproperty
    a_wake0_xfer: assert property (p_wake0_xfer) else $error("acc not loaded from wake0");

    property p_wake1_xfer;
        @(posedge MCLK) disable iff (RST)
        exec && op_w == 10'h259 |=> acc_q == $past(wake_q[1]) && hit_q;
    endproperty
    a_wake1_xfer: assert property (p_wake1_xfer) else $error("acc not loaded from wake1");

    property p_wake2_xfer;
        @(posedge MCLK) disable iff (RST)
        exec && op_w == 10'h25A |=> acc_q == $past(wake_q[2]) && hit_q;
    endproperty
    a_wake2_xfer: assert property (p_wake2_xfer) else $error("acc not loaded from wake2");

    property p_wake3_xfer;
        @(posedge MCLK) disable iff (RST)
        exec && op_w == 10'h25B |=> acc_q == $past(wake_q[3]) && hit_q;
    endproperty
    a_wake3_xfer: assert property (p_wake3_xfer) else $error("acc not loaded from wake3");

    property p_wake_kept;
        @(posedge MCLK) disable iff (RST)
        exec |=> wake_q[0] == $past(wake_q[0]) && wake_q[1] == $past(wake_q[1]) &&
            wake_q[2] == $past(wake_q[2]) && wake_q[3] == $past(wake_q[3]) &&
            int1_q == $past(int1_q);
    endproperty
    a_wake_kept: assert property (p_wake_kept) else $error("transfer disturbed a source");

    property p_carry_kept;
        @(posedge MCLK) disable iff (RST)
        exec |=> carry_q == $past(carry_q) ##1 !done_q;
    endproperty
    a_carry_kept: assert property (p_carry_kept) else $error("carry changed or long done");

    property p_no_hit_stable;
        @(posedge MCLK) disable iff (RST)
        exec && !dec_hit |=> $stable(acc_q) && !hit_q && !done_q;
    endproperty
    a_no_hit_stable: assert property (p_no_hit_stable) else $error("foreign opcode changed acc");

    property p_ack_bound;
        @(posedge MCLK) disable iff (RST)
        req && !ack_q |=> !AVS_WAITREQUEST;
    endproperty
    a_ack_bound: assert property (p_ack_bound) else $error("bus answer late");

    c_int1: cover property (@(posedge MCLK) disable iff (RST) exec && dec_src == SRC_INTCTL1);
    c_wake3: cover property (@(posedge MCLK) disable iff (RST) exec && dec_src == SRC_WAKE3);
    c_miss: cover property (@(posedge MCLK) disable iff (RST) exec && !dec_hit);
    c_read: cover property (@(posedge MCLK) disable iff (RST) AVS_READ && ack_q);

endmodule

`default_nettype wire

// File: verification/tb_accum_control_reg_transfer.sv
// Self-checking bench for the control-register transfer core.
// Assumes one wait state per bus request and software-issued opcodes.
`default_nettype none

module tb_accum_control_reg_transfer import acx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk, rst, avs_read, avs_write, avs_waitrequest, carry_out, xfer_done;
    logic [ADDR_W-1:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [BUS_W-1:0] avs_writedata, avs_readdata;
    logic [DATA_W-1:0] acc_out, m_acc;
    logic [DATA_W-1:0] m_reg [0:4];
    logic [OP_W-1:0] ops [0:4];
    logic [OP_W-1:0] m_ir;
    logic m_cy, m_hit;
    int n_fail, comparisons;

    acx_xfer_core uut (.MCLK(mclk), .RST(rst), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_BYTEENABLE(avs_byteenable),
        .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .ACC_OUT(acc_out), .CARRY_OUT(carry_out),
        .XFER_DONE(xfer_done));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        tally_and_finish();
    end

    task automatic chk(input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d,
                       input logic [3:0] be, output logic [BUS_W-1:0] r);
        int n;
        logic wq;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge mclk);
            // Pre-edge values; the slave's own updates land later in this step
            wq = avs_waitrequest;
            r = avs_readdata;
            n++;
        end while (wq !== 1'b0 && n < 20);
        if (wq !== 1'b0) begin
            n_fail++;
            tally_and_finish();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d,
                      input logic [3:0] be);
        logic [BUS_W-1:0] r;
        bus(1'b1, a, d, be, r);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [BUS_W-1:0] r);
        bus(1'b0, a, ~avs_writedata, 4'hF, r);
    endtask

    function automatic logic [ADDR_W-1:0] off(input int i);
        return OFS_INTCTL1 + ADDR_W'(4 * i);
    endfunction

    task automatic exec(input logic [OP_W-1:0] op, input logic [3:0] be);
        logic [BUS_W-1:0] r;
        logic [1:0] pulses;
        logic go;
        int idx;
        idx = -1;
        for (int i = 0; i < 5; i++) if (op === ops[i]) idx = i;
        go = (idx >= 0) && be[0] && be[1];
        wr(OFS_INSTR, {22'h0, op}, be);
        if (be[0] && be[1]) begin
            m_ir = op;
            m_hit = go;
        end
        if (go) m_acc = m_reg[idx];
        #1;
        chk(acc_out, m_acc);
        chk(carry_out, m_cy);
        pulses = {1'b0, xfer_done};
        @(posedge mclk);
        #1;
        pulses = pulses + {1'b0, xfer_done};
        chk(pulses, go);
        rd(OFS_STATUS, r);
        chk(r, m_hit);
        rd(OFS_ACC, r);
        chk(r, m_acc);
        rd(OFS_FLAGS, r);
        chk(r, m_cy);
        rd(OFS_INSTR, r);
        chk(r, m_ir);
    endtask

    initial begin
        logic [BUS_W-1:0] r, d;
        ops[0] = OP_XFER_INTCTL1;
        ops[1] = OP_XFER_WAKE0;
        ops[2] = 10'h259;
        ops[3] = 10'h25A;
        ops[4] = 10'h25B;
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = '0;
        avs_byteenable = 4'h0;
        avs_writedata = '0;
        m_acc = RST_NIBBLE;
        m_cy = 1'b0;
        m_hit = 1'b0;
        m_ir = RST_OPCODE;
        for (int i = 0; i < 5; i++) m_reg[i] = RST_NIBBLE;
        void'($urandom(32'h689C0280));
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        chk(acc_out, 32'h0);
        chk(carry_out, 32'h0);
        chk(xfer_done, 32'h0);
        for (int i = 0; i < 5; i++) begin
            rd(off(i), r);
            chk(r, 32'h0);
        end
        for (int k = 0; k < 8; k++) begin
            for (int i = 0; i < 5; i++) begin
                d = $urandom;
                m_reg[i] = d[3:0];
                wr(off(i), d, 4'hF);
            end
            d = $urandom;
            m_cy = d[0];
            // Skip bit written high must still read zero
            wr(OFS_FLAGS, d | 32'h2, 4'hF);
            for (int i = 0; i < 5; i++) begin
                rd(off(i), r);
                chk(r, m_reg[i]);
            end
            for (int i = 0; i < 5; i++) exec(ops[(i + k) % 5], 4'h3);
            d = $urandom;
            exec({1'b0, d[8:0]}, 4'hF);
            exec(k[0] ? 10'h257 : 10'h25C, 4'hF);
        end
        // Lane 0 off: write dropped; lane 1 off: opcode not issued
        d = $urandom;
        wr(off(2), d, 4'hE);
        rd(off(2), r);
        chk(r, m_reg[2]);
        exec(ops[4], 4'h1);
        wr(6'h3C, 32'hFFFFFFFF, 4'hF);
        rd(6'h3C, r);
        chk(r, 32'h0);
        tally_and_finish();
    end
endmodule

`default_nettype wire
